// ---- asc_defs.vh ----
// Constants for the asynchronous SRAM host controller
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH
`define ASC_ADDR_W 16
`define ASC_DATA_W 16
// Speed grade in ns; read access equals cycle time
`define ASC_T_CYCLE_NS 20
`define ASC_T_WP_NS 12
`define ASC_T_DW_NS 10
`define ASC_T_WHZ_NS 8
`define ASC_T_OHZ_NS 8
`define ASC_CLK_NS 8
// Least times round up to whole cycles
`define ASC_CEIL(t) (((t) + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_RD_CYC `ASC_CEIL(`ASC_T_CYCLE_NS)
`define ASC_WP_CYC `ASC_CEIL(`ASC_T_WP_NS)
`define ASC_TURN_CYC `ASC_CEIL(`ASC_T_OHZ_NS)
`define ASC_CNT_W 4
`define ASC_CNT_RST 4'h0
`endif

// ---- asc_sync2.v ----
// Two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
`default_nettype none
module asc_sync2 #(
  parameter W = 16
) (
  input wire clk,
  input wire arst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // asc_sync2
`default_nettype wire

// ---- asc_sram_host.v ----
// Host controller driving a 64K x 16 asynchronous SRAM with byte lanes
//
// Contract
// RQ1: Chip select high floats device, standby.
// RQ2: Lower lane read drives low byte.
// RQ3: Upper lane read drives high byte.
// RQ4: Both lanes read give full word.
// RQ5: Both lanes write store whole word.
// RQ6: Lower lane write keeps upper byte.
// RQ7: Upper lane write keeps lower byte.
// RQ8: Gate and strobe high float lanes.
// RQ9: Write only during all-low overlap.
// RQ10: Gate low: strobe covers turnoff plus setup.
// RQ11: Gate high: ordinary write pulse suffices.
// RQ12: Host never drives lanes device drives.
// RQ13: Selects low with strobe keep outputs off.
// RQ14: Read: strobe high, address before selects. The code sets word_addr on the same edge as the selects.
// RQ15: Device is static, no clock needed.
// RQ16: 65536 words of 16 bits.
// RQ17: Access time equals cycle time.
// RQ18: Readback returns last written lanes.
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.vh"
module asc_sram_host #(
  parameter AW = `ASC_ADDR_W,
  parameter DW = `ASC_DATA_W
) (
  input wire clk,
  input wire arst_n,
  input wire req_valid,
  input wire req_write,
  input wire [AW-1:0] req_addr,
  input wire [DW-1:0] req_wdata,
  input wire [1:0] req_lanes,
  output reg req_ready,
  output reg rsp_valid,
  output reg [DW-1:0] rsp_rdata,
  output reg [AW-1:0] word_addr,
  output reg chip_sel_n,
  output reg out_gate_n,
  output reg write_strobe_n,
  output reg lower_lane_sel_n,
  output reg upper_lane_sel_n,
  output reg [DW-1:0] data_lanes_o,
  output reg data_lanes_oe_n,
  input wire [DW-1:0] data_lanes_i
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RD = 5'h02;
  localparam [4:0] S_WR = 5'h04;
  localparam [4:0] S_REL = 5'h08;
  localparam [4:0] S_TURN = 5'h10;
  // Cycle counts are worked out as integers, then cut to the counter width
  localparam integer RD_I = `ASC_RD_CYC;
  localparam integer WP_I = `ASC_WP_CYC;
  localparam integer TURN_I = `ASC_TURN_CYC;
  localparam [`ASC_CNT_W-1:0] RD_CYC = RD_I[`ASC_CNT_W-1:0];
  localparam [`ASC_CNT_W-1:0] WP_CYC = WP_I[`ASC_CNT_W-1:0];
  localparam [`ASC_CNT_W-1:0] TURN_CYC = TURN_I[`ASC_CNT_W-1:0];

  reg [4:0] state_reg;
  reg [`ASC_CNT_W-1:0] cnt_reg;
  reg [1:0] lanes_reg;
  wire [DW-1:0] rd_sync;

  asc_sync2 #(.W(DW)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(data_lanes_i),
    .q(rd_sync)
  );

  // Keep only the lanes that were read; the others were floating
  function [DW-1:0] lane_mask;
    input [1:0] l;
    begin
      lane_mask = {{(DW/2){l[1]}}, {(DW/2){l[0]}}};
    end
  endfunction

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_IDLE;
      cnt_reg <= `ASC_CNT_RST;
      lanes_reg <= 2'h0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {DW{1'b0}};
      word_addr <= {AW{1'b0}};
      chip_sel_n <= 1'b1; // RQ1
      out_gate_n <= 1'b1;
      write_strobe_n <= 1'b1;
      lower_lane_sel_n <= 1'b1;
      upper_lane_sel_n <= 1'b1;
      data_lanes_o <= {DW{1'b0}};
      data_lanes_oe_n <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready && req_lanes != 2'h0) begin
            req_ready <= 1'b0;
            lanes_reg <= req_lanes;
            // Address settles with selects, not after them
            word_addr <= req_addr; // RQ14 RQ16
            chip_sel_n <= 1'b0;
            lower_lane_sel_n <= ~req_lanes[0]; // RQ2 RQ6
            upper_lane_sel_n <= ~req_lanes[1]; // RQ3 RQ7
            if (req_write) begin
              // Gate stays high so the device never drives here
              out_gate_n <= 1'b1; // RQ11 RQ12
              write_strobe_n <= 1'b0; // RQ9 RQ13
              data_lanes_o <= req_wdata;
              data_lanes_oe_n <= 1'b0; // RQ5
              cnt_reg <= WP_CYC;
              state_reg <= S_WR;
            end else begin
              out_gate_n <= 1'b0; // RQ4
              write_strobe_n <= 1'b1; // RQ14
              cnt_reg <= RD_CYC + 4'h2;
              state_reg <= S_RD;
            end
          end
        end
        S_RD: begin
          // Two extra cycles cover the input synchroniser
          if (cnt_reg == 4'h1) begin
            rsp_rdata <= rd_sync & lane_mask(lanes_reg); // RQ17
            rsp_valid <= 1'b1;
            out_gate_n <= 1'b1;
            chip_sel_n <= 1'b1;
            lower_lane_sel_n <= 1'b1;
            upper_lane_sel_n <= 1'b1;
            cnt_reg <= TURN_CYC;
            state_reg <= S_TURN; // RQ12
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        S_WR: begin
          if (cnt_reg == 4'h1) begin
            // Strobe rises first; data held one more cycle
            write_strobe_n <= 1'b1; // RQ9 RQ10
            state_reg <= S_REL;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        S_REL: begin
          data_lanes_oe_n <= 1'b1;
          chip_sel_n <= 1'b1;
          lower_lane_sel_n <= 1'b1;
          upper_lane_sel_n <= 1'b1;
          req_ready <= 1'b1;
          state_reg <= S_IDLE;
        end
        S_TURN: begin
          // Let device drivers turn off before next cycle
          if (cnt_reg == 4'h1) begin
            req_ready <= 1'b1;
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule // asc_sram_host
`default_nettype wire

// ---- asc_sram_model.sv ----
// Behavioural static memory on the host's far side
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model (
  input wire logic [15:0] a, d,
  input wire logic cs_n, oe_n, we_n, lb_n, ub_n,
  output logic [15:0] q
);
  logic [15:0] mem [0:65535];
  wire rd = !cs_n && !oe_n && we_n;
  // Store at the end of the overlap; lanes not selected keep old bytes
  always @(posedge we_n) begin
    if (!cs_n && !lb_n) mem[a][7:0] <= d[7:0];
    if (!cs_n && !ub_n) mem[a][15:8] <= d[15:8];
  end
  // A floating lane shows the inverse, never a plausible value
  assign q[7:0] = rd && !lb_n ? mem[a][7:0] : ~mem[a][7:0];
  assign q[15:8] = rd && !ub_n ? mem[a][15:8] : ~mem[a][15:8];
endmodule // asc_sram_model
`default_nettype wire

// ---- asc_sram_host_props.sv ----
// Checker for the host controller's pin sequencing
`timescale 1ns/1ps
`default_nettype none
module asc_sram_host_props (
  input wire clk, arst_n, req_valid, req_ready, rsp_valid,
  input wire [1:0] req_lanes,
  input wire [15:0] word_addr,
  input wire chip_sel_n, out_gate_n, write_strobe_n,
  input wire lower_lane_sel_n, upper_lane_sel_n, data_lanes_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_no_bus_fight: assert property (!data_lanes_oe_n |-> out_gate_n)
    else $error("host drives lanes while gate low");
  a_write_gate_high: assert property (!write_strobe_n |-> out_gate_n)
    else $error("gate low during write");
  a_strobe_width: assert property ($fell(write_strobe_n) |->
    !write_strobe_n[*2]) else $error("write pulse short");
  a_write_overlap: assert property (!write_strobe_n |-> !chip_sel_n &&
    !(lower_lane_sel_n && upper_lane_sel_n)) else $error("bad write");
  a_read_length: assert property ($fell(out_gate_n) |->
    !out_gate_n[*3]) else $error("read shorter than cycle");
  a_read_strobe: assert property (!out_gate_n |-> write_strobe_n)
    else $error("strobe low in read");
  a_addr_steady: assert property (!chip_sel_n && !$past(chip_sel_n) |->
    $stable(word_addr)) else $error("address moved");
  a_take_busy: assert property (req_valid && req_ready && req_lanes != 2'h0
    |=> !req_ready) else $error("ready after take");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  c_write: cover property ($fell(write_strobe_n));
  c_read: cover property ($fell(out_gate_n));
  c_rsp: cover property (rsp_valid);
endmodule // asc_sram_host_props
bind asc_sram_host asc_sram_host_props i_props (.*);
`default_nettype wire

// ---- test_asc_sram_host.sv ----
// Self-checking bench for the host controller with a memory model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module test_asc_sram_host;
  logic clk = 0, arst_n = 0, req_valid = 0, req_write = 0;
  logic [15:0] req_addr = 0, req_wdata = 0;
  logic [1:0] req_lanes = 0;
  int miscompares = 0, compares = 0, cycles = 0;
  wire req_ready, rsp_valid, chip_sel_n, out_gate_n, write_strobe_n;
  wire lower_lane_sel_n, upper_lane_sel_n, data_lanes_oe_n;
  wire [15:0] rsp_rdata, word_addr, data_lanes_o, data_lanes_i, q;
  assign data_lanes_i = data_lanes_oe_n ? q : data_lanes_o;
  asc_sram_host i_dut (.*);
  asc_sram_model i_mem (.a(word_addr), .d(data_lanes_i), .cs_n(chip_sel_n),
    .oe_n(out_gate_n), .we_n(write_strobe_n), .lb_n(lower_lane_sel_n),
    .ub_n(upper_lane_sel_n), .q(q));
  always #4 clk = ~clk;
  task req(input logic w, input logic [15:0] a, d, input logic [1:0] l);
    repeat (50) if (req_ready === 1'b1) break; else @(negedge clk);
    req_valid = 1; req_write = w; req_addr = a; req_wdata = d; req_lanes = l;
    @(negedge clk);
    req_valid = 0;
  endtask
  task rd(input logic [15:0] a, e, input logic [1:0] l);
    req(0, a, 16'h0, l);
    repeat (10) if (rsp_valid === 1'b1) break; else @(negedge clk);
    `CHK(rsp_valid, 1'b1)
    `CHK(rsp_rdata, e)
  endtask
  task t_word;
    req(1, 16'h0000, 16'ha5c3, 2'h3);
    req(1, 16'hffff, 16'h1234, 2'h3);
    rd(16'h0000, 16'ha5c3, 2'h3);
    rd(16'hffff, 16'h1234, 2'h3);
    $display("test word done");
  endtask
  task t_lanes;
    req(1, 16'h0010, 16'h1122, 2'h3);
    req(1, 16'h0010, 16'h55ab, 2'h1);
    req(1, 16'h0010, 16'hcd66, 2'h2);
    rd(16'h0010, 16'hcdab, 2'h3);
    rd(16'h0010, 16'h00ab, 2'h1);
    rd(16'h0010, 16'hcd00, 2'h2);
    $display("test lanes done");
  endtask
  task t_refuse;
    req(1, 16'h0010, 16'hffff, 2'h0);
    `CHK(req_ready, 1'b1)
    `CHK(chip_sel_n, 1'b1)
    rd(16'h0010, 16'hcdab, 2'h3);
    $display("test refuse done");
  endtask
  task tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1;
    repeat (2) @(negedge clk);
    t_word;
    t_lanes;
    t_refuse;
    tally_and_finish;
  end
endmodule // test_asc_sram_host
`default_nettype wire
